// ### hw/sample_fifo_pkg.sv
// constants and carrier types shared by the sample buffer control files
// assumes byte-wide registers reached through the link-side byte port
package sample_fifo_pkg;

  // ****************************************************
  // sizes
  // ****************************************************
  localparam int DEPTH = 32;
  localparam int COUNT_W = 6;
  localparam int PTR_W = 5;
  localparam int BYTES_PER_SAMPLE = 5;
  localparam int BYTE_IDX_W = 3;
  localparam int SYNC_STAGES = 3;

  // ****************************************************
  // register offsets and fields
  // ****************************************************
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h0E;
  localparam logic [7:0] ADDR_FIFO_SETUP = 8'h0F;
  localparam logic [7:0] ADDR_TICK_DELAY = 8'h10;
  localparam logic [7:0] ADDR_SYS_MODE = 8'h11;
  localparam int SETUP_MODE_MSB = 7;
  localparam int SETUP_MODE_LSB = 6;
  localparam int SETUP_WMRK_MSB = 5;
  localparam int SETUP_WMRK_LSB = 0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [5:0] WMRK_RESET = 6'h00;
  localparam logic [5:0] WMRK_OFF = 6'h00;
  localparam logic [7:0] DELAY_RESET = 8'h00;
  localparam logic [7:0] DELAY_MAX = 8'hFF;
  localparam logic [7:0] READ_DEFAULT = 8'h00;
  localparam logic [6:0] SYS_MODE_RSVD = 7'h00;
  localparam logic [5:0] COUNT_EMPTY = 6'h00;
  localparam logic [5:0] COUNT_FULL = 6'h20;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h4;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    POLICY_OFF = 2'h0,
    POLICY_CIRCULAR = 2'h1,
    POLICY_HALT = 2'h2,
    POLICY_UNUSED = 2'h3
  } policy_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] pressureHigh;
    logic [7:0] pressureMid;
    logic [7:0] pressureLow;
    logic [7:0] tempHigh;
    logic [7:0] tempLow;
  } sample_t;

  typedef struct packed {
    logic overflowFlag;
    logic watermarkFlag;
    logic [5:0] storedSampleCount;
  } fifo_status_t;

  localparam int SAMPLE_W = $bits(sample_t);

endpackage : sample_fifo_pkg

// ### hw/two_entry_buffer.sv
// small flop buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 2,
  parameter int IDX_W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam logic [IDX_W:0] LEVEL_FULL = (IDX_W+1)'(DEPTH);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH-1);
  localparam logic [IDX_W-1:0] IDX_ZERO = '0;

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [IDX_W-1:0] wrIdx_reg;
  logic [IDX_W-1:0] rdIdx_reg;
  logic [IDX_W:0] level_reg;
  logic [IDX_W:0] level_next;
  wire pushFire = inValid && (level_reg != LEVEL_FULL);
  wire popFire = outReady && (level_reg != '0);
  wire [IDX_W-1:0] wrIdxInc = (wrIdx_reg == IDX_LAST) ? IDX_ZERO
                              : IDX_W'(wrIdx_reg + 1'b1);
  wire [IDX_W-1:0] rdIdxInc = (rdIdx_reg == IDX_LAST) ? IDX_ZERO
                              : IDX_W'(rdIdx_reg + 1'b1);

  assign level_next = (pushFire && !popFire) ? (IDX_W+1)'(level_reg + 1'b1)
                    : (popFire && !pushFire) ? (IDX_W+1)'(level_reg - 1'b1)
                    : level_reg;
  assign inReady = (level_reg != LEVEL_FULL);
  assign outValid = (level_reg != '0);
  assign outData = store_reg[rdIdx_reg];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrIdx_reg <= '0;
      rdIdx_reg <= '0;
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
      if (pushFire) wrIdx_reg <= wrIdxInc;
      if (popFire) rdIdx_reg <= rdIdxInc;
    end
  end

  always_ff @(posedge clk) begin
    if (pushFire) store_reg[wrIdx_reg] <= inData;
  end

endmodule : two_entry_buffer

// ### hw/sample_fifo_control.sv
// control of the 32-sample measurement buffer: policy, flags, delay
// counter, mode indication and the link-side byte register port
// assumes systemActive and sampleTick come from logic on sys_clk and
// that the link side presents one register request at a time
//
// What this block does
// - decode policy: off, circular, halt on full
// - circular: full buffer drops oldest, stores newest
// - halt: full buffer ignores new samples
// - flush when disabled or on standby-to-active
// - disabling clears overflow, watermark and count
// - overflow flag set when count reaches 32
// - watermark flag when count equals watermark
// - zero watermark never raises watermark flag
// - policy writable anytime except a direct circular-halt swap, watermark only in standby
// - eight-bit counter of sample ticks
// - counter runs only after overflow or wrap
// - counter clears when final byte is read
// - mode bit 0: standby 0, active 1
// - mode register upper seven bits read zero
// - six-bit count, zero empty, up to 32
// - byte reads return oldest sample, then remove
`timescale 1ns/1ps
module sample_fifo_control (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link-side register port
  input wire logic linkClk,
  input wire logic regReqValid,
  input wire sample_fifo_pkg::reg_req_t regReq,
  output logic regReqReady,
  output logic regRspValid,
  output logic [7:0] regRspData,
  // incoming samples
  input wire logic sampleValid,
  input wire sample_fifo_pkg::sample_t sampleIn,
  output logic sampleReady,
  input wire logic sampleTick,
  // system mode
  input wire logic systemActive,
  // state toward the status and interrupt logic
  output sample_fifo_pkg::fifo_status_t fifoStatus
);

  // ****************************************************
  // decoding helpers
  // ****************************************************
  function automatic logic policy_on(input logic [1:0] mode);
    // the unused code stores nothing, like the off code
    policy_on = (mode == sample_fifo_pkg::POLICY_CIRCULAR) ||
                (mode == sample_fifo_pkg::POLICY_HALT);
  endfunction : policy_on

  function automatic logic [7:0] sample_byte(
    input sample_fifo_pkg::sample_t s,
    input logic [2:0] idx
  );
    case (idx)
      3'h0: sample_byte = s.pressureHigh;
      3'h1: sample_byte = s.pressureMid;
      3'h2: sample_byte = s.pressureLow;
      3'h3: sample_byte = s.tempHigh;
      3'h4: sample_byte = s.tempLow;
      default: sample_byte = sample_fifo_pkg::READ_DEFAULT;
    endcase
  endfunction : sample_byte

  // ****************************************************
  // link domain: request capture and answer
  // ****************************************************
  sample_fifo_pkg::reg_req_t linkReq_reg;
  logic reqTog_reg;
  logic ackSync1_reg;
  logic ackSync2_reg;
  logic ackSync3_reg;
  logic ackSeen_reg;
  logic regReqReady_reg;
  logic regRspValid_reg;
  logic [7:0] regRspData_reg;
  logic [7:0] rspData_reg;
  logic ackTog_reg;

  wire linkTake = regReqValid && regReqReady_reg;
  // an edge counts only once the two later stages agree
  wire ackEvent = (ackSync2_reg == ackSync3_reg) &&
                  (ackSync3_reg != ackSeen_reg);

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      ackSync1_reg <= 1'b0;
      ackSync2_reg <= 1'b0;
      ackSync3_reg <= 1'b0;
    end else begin
      ackSync1_reg <= ackTog_reg;
      ackSync2_reg <= ackSync1_reg;
      ackSync3_reg <= ackSync2_reg;
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkReq_reg <= '0;
      reqTog_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      regReqReady_reg <= 1'b1;
      regRspValid_reg <= 1'b0;
      regRspData_reg <= sample_fifo_pkg::READ_DEFAULT;
    end else begin
      regRspValid_reg <= ackEvent;
      if (linkTake) begin
        // request stays frozen until the core answers
        linkReq_reg <= regReq;
        reqTog_reg <= ~reqTog_reg;
        regReqReady_reg <= 1'b0;
      end else if (ackEvent) begin
        ackSeen_reg <= ackSync3_reg;
        regReqReady_reg <= 1'b1;
        regRspData_reg <= rspData_reg;
      end
    end
  end

  assign regReqReady = regReqReady_reg;
  assign regRspValid = regRspValid_reg;
  assign regRspData = regRspData_reg;

  // ****************************************************
  // system domain: request arrival
  // ****************************************************
  logic reqSync1_reg;
  logic reqSync2_reg;
  logic reqSync3_reg;
  logic reqSeen_reg;

  wire reqEvent = (reqSync2_reg == reqSync3_reg) &&
                  (reqSync3_reg != reqSeen_reg);
  // safe to sample: the link side holds the request until answered
  wire sample_fifo_pkg::reg_req_t req = linkReq_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reqSync1_reg <= 1'b0;
      reqSync2_reg <= 1'b0;
      reqSync3_reg <= 1'b0;
      reqSeen_reg <= 1'b0;
    end else begin
      reqSync1_reg <= reqTog_reg;
      reqSync2_reg <= reqSync1_reg;
      reqSync3_reg <= reqSync2_reg;
      if (reqEvent) reqSeen_reg <= reqSync3_reg;
    end
  end

  // ****************************************************
  // setup register and mode tracking
  // ****************************************************
  logic [1:0] mode_reg;
  logic [5:0] wmrk_reg;
  logic prevActive_reg;

  wire hitData = (req.addr == sample_fifo_pkg::ADDR_FIFO_DATA);
  wire hitSetup = (req.addr == sample_fifo_pkg::ADDR_FIFO_SETUP);
  wire hitDelay = (req.addr == sample_fifo_pkg::ADDR_TICK_DELAY);
  wire hitMode = (req.addr == sample_fifo_pkg::ADDR_SYS_MODE);
  wire writeSetup = reqEvent && req.write && hitSetup;
  wire [1:0] wrMode = req.wdata[sample_fifo_pkg::SETUP_MODE_MSB:
                                sample_fifo_pkg::SETUP_MODE_LSB];
  wire [5:0] wrWmrk = req.wdata[sample_fifo_pkg::SETUP_WMRK_MSB:
                                sample_fifo_pkg::SETUP_WMRK_LSB];
  // a direct jump between the two storing policies is refused
  wire directSwap = policy_on(mode_reg) && policy_on(wrMode) &&
                    (wrMode != mode_reg);
  wire modeWrOk = writeSetup && !directSwap;
  wire wmrkWrOk = writeSetup && !systemActive;
  wire policyOn = policy_on(mode_reg);
  wire isCircular = (mode_reg == sample_fifo_pkg::POLICY_CIRCULAR);
  wire isHalt = (mode_reg == sample_fifo_pkg::POLICY_HALT);
  wire goActive = systemActive && !prevActive_reg;
  wire flush = !policyOn || goActive;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= sample_fifo_pkg::MODE_RESET;
      wmrk_reg <= sample_fifo_pkg::WMRK_RESET;
      prevActive_reg <= 1'b0;
    end else begin
      prevActive_reg <= systemActive;
      if (modeWrOk) mode_reg <= wrMode;
      if (wmrkWrOk) wmrk_reg <= wrWmrk;
    end
  end

  // ****************************************************
  // sample intake
  // ****************************************************
  sample_fifo_pkg::sample_t bufData;
  logic bufValid;
  logic bufReady;

  // intake pauses for a cycle of register access, so a push and a pop
  // never meet; the small buffer absorbs the pause
  wire intakeReady = !reqEvent;
  logic sampleReady_reg;
  wire takeSample = sampleValid && sampleReady_reg;
  // ready is a flop, so it must foresee a buffer that fills on this edge
  wire nextFull = !(bufValid && intakeReady) &&
                  (!bufReady || (bufValid && takeSample));

  two_entry_buffer #(
    .WIDTH(sample_fifo_pkg::SAMPLE_W),
    .DEPTH(2),
    .IDX_W(1)
  ) u_intake (
    .clk(sys_clk),
    .rst(rst),
    .inValid(takeSample),
    .inData(sampleIn),
    .inReady(bufReady),
    .outValid(bufValid),
    .outData(bufData),
    .outReady(intakeReady)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sampleReady_reg <= 1'b0;
    else sampleReady_reg <= !nextFull;
  end

  assign sampleReady = sampleReady_reg;

  // ****************************************************
  // storage, pointers and count
  // ****************************************************
  sample_fifo_pkg::sample_t mem_reg [sample_fifo_pkg::DEPTH];
  logic [sample_fifo_pkg::PTR_W-1:0] wrPtr_reg;
  logic [sample_fifo_pkg::PTR_W-1:0] rdPtr_reg;
  logic [sample_fifo_pkg::BYTE_IDX_W-1:0] byteIdx_reg;
  logic [sample_fifo_pkg::COUNT_W-1:0] count_reg;
  logic [sample_fifo_pkg::COUNT_W-1:0] count_next;

  wire inFire = bufValid && intakeReady;
  wire isFull = (count_reg == sample_fifo_pkg::COUNT_FULL);
  wire isEmpty = (count_reg == sample_fifo_pkg::COUNT_EMPTY);
  wire store = inFire && policyOn && !flush &&
               (!isFull || isCircular);
  wire overwrite = store && isFull;
  wire dropFull = inFire && isHalt && isFull && !flush;
  wire readData = reqEvent && !req.write && hitData;
  wire popByte = readData && !isEmpty && !flush;
  wire lastByte = (byteIdx_reg == sample_fifo_pkg::LAST_BYTE_IDX);
  wire popDone = popByte && lastByte;
  wire finalByte = popDone &&
                   (count_reg == sample_fifo_pkg::COUNT_W'(1));
  wire [7:0] headByte = sample_byte(mem_reg[rdPtr_reg], byteIdx_reg);
  wire reachFull = store && !isFull &&
                   (count_reg == sample_fifo_pkg::COUNT_W'(
                     sample_fifo_pkg::DEPTH - 1));
  wire ovfEvent = reachFull || overwrite || dropFull;

  assign count_next = flush ? sample_fifo_pkg::COUNT_EMPTY
                    : (store && !overwrite)
                      ? sample_fifo_pkg::COUNT_W'(count_reg + 1'b1)
                    : popDone ? sample_fifo_pkg::COUNT_W'(count_reg - 1'b1)
                    : count_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      byteIdx_reg <= '0;
      count_reg <= sample_fifo_pkg::COUNT_EMPTY;
    end else begin
      count_reg <= count_next;
      if (flush) begin
        wrPtr_reg <= '0;
        rdPtr_reg <= '0;
        byteIdx_reg <= '0;
      end else begin
        if (store) wrPtr_reg <= sample_fifo_pkg::PTR_W'(wrPtr_reg + 1'b1);
        // a replaced head restarts at its first byte
        if (overwrite || popDone) begin
          rdPtr_reg <= sample_fifo_pkg::PTR_W'(rdPtr_reg + 1'b1);
          byteIdx_reg <= '0;
        end else if (popByte) begin
          byteIdx_reg <= sample_fifo_pkg::BYTE_IDX_W'(byteIdx_reg + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (store) mem_reg[wrPtr_reg] <= bufData;
  end

  // ****************************************************
  // flags
  // ****************************************************
  logic overflow_reg;
  logic watermark_reg;

  wire wmrkOn = (wmrk_reg != sample_fifo_pkg::WMRK_OFF);
  // set on the match and held while the count stays at or above it
  wire wmrkNext = wmrkOn && (count_next >= wmrk_reg) &&
                  (watermark_reg || count_next == wmrk_reg);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_reg <= 1'b0;
      watermark_reg <= 1'b0;
    end else begin
      watermark_reg <= !flush && wmrkNext;
      if (flush) overflow_reg <= 1'b0;
      else if (ovfEvent) overflow_reg <= 1'b1;
    end
  end

  // ****************************************************
  // tick delay counter
  // ****************************************************
  logic delayRun_reg;
  logic [7:0] delay_reg;

  wire delayClear = flush || finalByte;
  wire delaySat = (delay_reg == sample_fifo_pkg::DELAY_MAX);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      delayRun_reg <= 1'b0;
      delay_reg <= sample_fifo_pkg::DELAY_RESET;
    end else begin
      if (delayClear) delayRun_reg <= 1'b0;
      else if (ovfEvent) delayRun_reg <= 1'b1;
      if (delayClear || store) begin
        delay_reg <= sample_fifo_pkg::DELAY_RESET;
      end else if (sampleTick && delayRun_reg && !delaySat) begin
        delay_reg <= 8'(delay_reg + 1'b1);
      end
    end
  end

  // ****************************************************
  // read answers
  // ****************************************************
  wire [7:0] modeByte = {sample_fifo_pkg::SYS_MODE_RSVD,
                         systemActive};
  wire [7:0] dataByte = popByte ? headByte
                        : sample_fifo_pkg::READ_DEFAULT;
  wire [7:0] readMux = req.write ? sample_fifo_pkg::READ_DEFAULT
                     : hitData ? dataByte
                     : hitSetup ? {mode_reg, wmrk_reg}
                     : hitDelay ? delay_reg
                     : hitMode ? modeByte
                     : sample_fifo_pkg::READ_DEFAULT;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspData_reg <= sample_fifo_pkg::READ_DEFAULT;
      ackTog_reg <= 1'b0;
    end else if (reqEvent) begin
      rspData_reg <= readMux;
      ackTog_reg <= ~ackTog_reg;
    end
  end

  assign fifoStatus.overflowFlag = overflow_reg;
  assign fifoStatus.watermarkFlag = watermark_reg;
  assign fifoStatus.storedSampleCount = count_reg;

endmodule : sample_fifo_control

// ### dv/sample_fifo_control_properties.sv
// concurrent checks on the sample buffer control ports
// assumes it is bound to sample_fifo_control and sees its ports only
`timescale 1ns/1ps
module sample_fifo_control_properties (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic linkClk,
  input wire logic rst,
  // watched ports
  input wire logic regReqValid,
  input wire logic regReqReady,
  input wire logic regRspValid,
  input wire logic systemActive,
  input wire sample_fifo_pkg::fifo_status_t fifoStatus
);
  // ****************************************************
  // buffer state
  // ****************************************************
  wire [5:0] cnt = fifoStatus.storedSampleCount;

  a_count_range:
    assert property (@(posedge sys_clk) disable iff (rst)
    cnt <= sample_fifo_pkg::COUNT_FULL) else $error("count above full");
  a_count_step:
    assert property (@(posedge sys_clk) disable iff (rst)
    cnt != $past(cnt) |-> cnt == $past(cnt) + 6'h01 ||
    cnt == $past(cnt) - 6'h01 || cnt == 6'h00)
    else $error("count jumped");
  a_ovf_set:
    assert property (@(posedge sys_clk) disable iff (rst)
    $rose(fifoStatus.overflowFlag) |-> cnt == sample_fifo_pkg::COUNT_FULL)
    else $error("overflow below full");
  a_ovf_clear:
    assert property (@(posedge sys_clk) disable iff (rst)
    $fell(fifoStatus.overflowFlag) |-> cnt == 6'h00)
    else $error("overflow dropped without flush");
  a_wmrk_nonzero:
    assert property (@(posedge sys_clk) disable iff (rst)
    fifoStatus.watermarkFlag |-> cnt != 6'h00)
    else $error("watermark with empty buffer");
  // the flush lands on the edge that first sees the rise
  a_flush_active:
    assert property (@(posedge sys_clk) disable iff (rst)
    $rose(systemActive) |=> cnt == 6'h00 && !fifoStatus.overflowFlag)
    else $error("no flush on activation");

  // ****************************************************
  // register port
  // ****************************************************
  a_rsp_bound:
    assert property (@(posedge linkClk) disable iff (rst)
    regReqValid && regReqReady |-> ##[1:10] regRspValid)
    else $error("no answer in time");
  a_ready_blocked:
    assert property (@(posedge linkClk) disable iff (rst)
    regReqValid && regReqReady |=> !regReqReady until regRspValid)
    else $error("second request taken early");
  a_rsp_pulse:
    assert property (@(posedge linkClk) disable iff (rst)
    regRspValid |=> !regRspValid) else $error("answer longer than a cycle");

  c_ovf: cover property (@(posedge sys_clk) $rose(fifoStatus.overflowFlag));
  c_wmrk: cover property (@(posedge sys_clk) $rose(fifoStatus.watermarkFlag));
  c_rsp: cover property (@(posedge linkClk) regRspValid);
endmodule : sample_fifo_control_properties

bind sample_fifo_control sample_fifo_control_properties u_props (
  .sys_clk(sys_clk), .linkClk(linkClk), .rst(rst),
  .regReqValid(regReqValid), .regReqReady(regReqReady),
  .regRspValid(regRspValid), .systemActive(systemActive),
  .fifoStatus(fifoStatus)
);

// ### dv/host_reg_model.sv
// host model: issues register requests on the link clock
// assumes one request at a time and answers within twelve link cycles
`timescale 1ns/1ps
module host_reg_model (
  // link clock
  input wire logic linkClk,
  // request and answer
  output logic regReqValid,
  output sample_fifo_pkg::reg_req_t regReq,
  input wire logic regReqReady,
  input wire logic regRspValid,
  input wire logic [7:0] regRspData
);
  logic [1:0] policy = 2'h0;
  int timeouts = 0;
  initial begin
    regReqValid = 1'b0;
    regReq = '0;
  end

  task automatic access(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(negedge linkClk);
    regReq = '{a, w, d};
    regReqValid = 1'b1;
    while (regReqReady !== 1'b1 && n < 12) begin
      @(negedge linkClk);
      n++;
    end
    @(negedge linkClk);
    regReqValid = 1'b0;
    // released lines show no stale request
    regReq = sample_fifo_pkg::reg_req_t'(~regReq);
    while (regRspValid !== 1'b1 && n < 24) begin
      @(negedge linkClk);
      n++;
    end
    if (n >= 12) timeouts++;
    q = regRspData;
  endtask : access

  task automatic setup(input logic [7:0] v);
    logic [7:0] q;
    if (policy != 2'h0 && v[7:6] != 2'h0 && v[7:6] != policy)
      access(sample_fifo_pkg::ADDR_FIFO_SETUP, 1'b1, {2'h0, v[5:0]}, q);
    access(sample_fifo_pkg::ADDR_FIFO_SETUP, 1'b1, v, q);
    policy = v[7:6];
  endtask : setup
endmodule : host_reg_model

// ### dv/sample_fifo_control_tb_top.sv
// self-checking bench for the sample buffer control
// assumes the host model drives the register port
`timescale 1ns/1ps
module sample_fifo_control_tb_top;
  localparam logic [7:0] DATA = sample_fifo_pkg::ADDR_FIFO_DATA;
  localparam logic [7:0] SETUP = sample_fifo_pkg::ADDR_FIFO_SETUP;
  localparam logic [7:0] DLY = sample_fifo_pkg::ADDR_TICK_DELAY;
  localparam logic [7:0] MODE = sample_fifo_pkg::ADDR_SYS_MODE;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst;
  logic regReqValid, regReqReady, regRspValid, sampleReady;
  sample_fifo_pkg::reg_req_t regReq;
  logic [7:0] regRspData;
  logic sampleValid;
  sample_fifo_pkg::sample_t sampleIn;
  logic sampleTick;
  logic systemActive;
  sample_fifo_pkg::fifo_status_t fifoStatus;
  int n_mismatch = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;
  initial begin
    #17;
    forever #40 linkClk = ~linkClk;
  end

  sample_fifo_control DUT (
    .sys_clk(sys_clk), .rst(rst), .linkClk(linkClk),
    .regReqValid(regReqValid), .regReq(regReq), .regReqReady(regReqReady),
    .regRspValid(regRspValid), .regRspData(regRspData),
    .sampleValid(sampleValid), .sampleIn(sampleIn),
    .sampleReady(sampleReady), .sampleTick(sampleTick),
    .systemActive(systemActive), .fifoStatus(fifoStatus)
  );
  host_reg_model host (
    .linkClk(linkClk), .regReqValid(regReqValid), .regReq(regReq),
    .regReqReady(regReqReady), .regRspValid(regRspValid),
    .regRspData(regRspData)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic guard(input bit hung);
    if (hung || host.timeouts != 0) begin
      n_mismatch++;
      stop_test();
    end
  endtask : guard

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.access(a, 1'b0, 8'h00, q);
    guard(1'b0);
    chk($sformatf("reg %h", a), exp, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(a, 1'b1, d, q);
    guard(1'b0);
  endtask : wr

  function automatic sample_fifo_pkg::sample_t mk(input int k);
    mk = {8'(k), 8'(k + 40), 8'(k + 80), 8'(k + 120), 8'(k + 160)};
  endfunction : mk

  // ready is a flop output, so it is read at the falling edge
  task automatic push(input int k0, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      sampleValid = 1'b1;
      sampleIn = mk(k0 + i);
      w = 0;
      while (sampleReady !== 1'b1 && w < 50) begin
        @(negedge sys_clk);
        w++;
      end
      guard(w >= 50);
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    sampleValid = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask : push

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      sampleTick = 1'b1;
      @(negedge sys_clk);
      sampleTick = 1'b0;
    end
  endtask : tick

  task automatic st(input logic [7:0] exp);
    repeat (4) @(negedge sys_clk);
    chk("status", exp, fifoStatus);
  endtask : st

  task automatic rdsample(input int k);
    sample_fifo_pkg::sample_t s;
    s = mk(k);
    for (int j = 0; j < 5; j++) rd(DATA, s[39 - 8 * j -: 8]);
  endtask : rdsample

  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    rst = 1'b1;
    sampleValid = 1'b0;
    sampleIn = '0;
    sampleTick = 1'b0;
    systemActive = 1'b0;
    repeat (20) @(negedge sys_clk);
    // the link side needs a few of its own edges in reset too
    repeat (3) @(posedge linkClk);
    @(negedge sys_clk);
    rst = 1'b0;
    rd(SETUP, 8'h00);
    rd(DLY, 8'h00);
    rd(MODE, 8'h00);
    rd(8'h20, 8'h00);
    wr(MODE, 8'hFF);
    rd(MODE, 8'h00);
    push(0, 2);
    st(8'h00);
    host.setup(8'h43);
    rd(SETUP, 8'h43);
    push(0, 2);
    st(8'h02);
    tick(2);
    rd(DLY, 8'h00);
    push(2, 1);
    st(8'h43);
    push(3, 1);
    st(8'h44);
    @(negedge sys_clk);
    systemActive = 1'b1;
    st(8'h00);
    rd(MODE, 8'h01);
    wr(SETUP, 8'h45);
    rd(SETUP, 8'h43);
    @(negedge sys_clk);
    systemActive = 1'b0;
    host.setup(8'h40);
    push(10, 33);
    st(8'hA0);
    tick(3);
    rd(DLY, 8'h03);
    rdsample(11);
    st(8'h9F);
    rd(DLY, 8'h03);
    for (int k = 12; k < 43; k++) rdsample(k);
    rd(DLY, 8'h00);
    rd(DATA, 8'h00);
    host.setup(8'h00);
    st(8'h00);
    host.setup(8'h80);
    push(50, 34);
    st(8'hA0);
    rdsample(50);
    // a direct swap keeps the policy but still takes the watermark
    wr(SETUP, 8'h41);
    rd(SETUP, 8'h81);
    host.setup(8'h41);
    rd(SETUP, 8'h41);
    st(8'h00);
    host.setup(8'hC0);
    push(60, 2);
    st(8'h00);
    stop_test();
  end
endmodule : sample_fifo_control_tb_top
